// ---- verilog/socrc_ctrl.sv ----
// slow oscillator control, frequency measurement and reset-cause record
`timescale 1ns/1ps
module socrc_ctrl
  import socrc_pkg::*;
#(
  parameter int ADDR_W  = 8,
  parameter int CNT_W   = COUNT_W,
  parameter int PERIODS = SLOW_PERIODS
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_por_b,
  input  wire logic              i_clk_en,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic              i_slow_osc_clock,
  input  wire logic              i_fast_osc_tick,
  input  wire logic              i_slow_osc_stable,
  input  wire socrc_cause_t      i_reset_cause,
  output logic      [TRIM_W-1:0] o_slow_osc_trim,
  output logic                   o_irq
);

  localparam int PW = $clog2(PERIODS + 1);

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk_addr
    $error("ADDR_W must lie in 8..32");
  end
  if (CNT_W < 4 || CNT_W > COUNT_W) begin : g_chk_cnt
    $error("CNT_W must lie in 4..16");
  end
  if (PERIODS < 1) begin : g_chk_per
    $error("PERIODS must be at least 1");
  end

  // address decode shared by read and write paths
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  socrc_state_t      state;
  socrc_state_t      next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [CNT_W-1:0]  count;
  logic [CNT_W-1:0]  next_count;
  logic [PW-1:0]     periods;
  logic [PW-1:0]     next_periods;
  logic              done;
  logic              next_done;
  logic              slow_q;
  logic              next_slow_q;
  socrc_ctrl_t       ctrl;
  socrc_ctrl_t       next_ctrl;
  logic              ready;
  logic              next_ready;
  logic              clr_bit;
  logic              next_clr_bit;
  socrc_cause_t      cause;
  socrc_cause_t      next_cause;
  logic [IRQ_W-1:0]  ists;
  logic [IRQ_W-1:0]  next_ists;
  logic [IRQ_W-1:0]  ien;
  logic [IRQ_W-1:0]  next_ien;
  logic [IRQ_W-1:0]  iev;
  logic              next_irq;
  logic              next_pready;
  logic              next_pslverr;
  logic [31:0]       next_prdata;
  logic [31:0]       ctrl_word;
  logic [31:0]       cause_word;
  logic              acc;
  logic              commit;
  logic              wr;
  logic              mapped;
  logic              wr_ctrl;
  logic              wr_cause;
  logic              wr_iclr;
  logic              wr_ien;
  logic              cause_clr;
  logic              slow_rise;
  logic              done_ev;
  logic              cause_ev;

  // apb decode
  assign acc      = i_psel & i_penable;
  assign commit   = acc & o_pready;
  assign wr       = commit & i_pwrite;
  assign wr_ctrl  = wr & hit(i_paddr, SOCRC_CTRL_OFS);
  assign wr_cause = wr & hit(i_paddr, SOCRC_CAUSE_OFS);
  assign wr_iclr  = wr & hit(i_paddr, SOCRC_ICLR_OFS);
  assign wr_ien   = wr & hit(i_paddr, SOCRC_IEN_OFS);
  assign mapped   = hit(i_paddr, SOCRC_CTRL_OFS)
                  | hit(i_paddr, SOCRC_CAUSE_OFS)
                  | hit(i_paddr, SOCRC_ISTS_OFS)
                  | hit(i_paddr, SOCRC_ICLR_OFS)
                  | hit(i_paddr, SOCRC_IEN_OFS);

  // read words, unlisted bits stay zero
  always_comb begin
    ctrl_word = '0;
    ctrl_word[DONE_POS] = done;
    ctrl_word[COUNT_LSB +: COUNT_W] = COUNT_W'(count);
    ctrl_word[EN_POS] = ctrl.enable;
    ctrl_word[TRIM_LSB +: TRIM_W] = ctrl.trim;
    ctrl_word[READY_POS] = ready;
  end

  always_comb begin
    cause_word = '0;
    for (int i = 0; i < CAUSE_W; i++) begin
      cause_word[CAUSE_POS[i]] = cause[i];
    end
    cause_word[CLR_POS] = clr_bit;
  end

  // apb answer, one wait state
  always_comb begin
    next_pready  = acc & ~o_pready;
    next_pslverr = acc & ~o_pready & ~mapped;
    next_prdata  = '0;
    if (acc && !o_pready && !i_pwrite) begin
      if (hit(i_paddr, SOCRC_CTRL_OFS)) begin
        next_prdata = ctrl_word;
      end else if (hit(i_paddr, SOCRC_CAUSE_OFS)) begin
        next_prdata = cause_word;
      end else if (hit(i_paddr, SOCRC_ISTS_OFS)) begin
        next_prdata = 32'(ists);
      end else if (hit(i_paddr, SOCRC_IEN_OFS)) begin
        next_prdata = 32'(ien);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
    end else if (i_clk_en) begin
      o_pready  <= next_pready;
      o_pslverr <= next_pslverr;
      o_prdata  <= next_prdata;
    end
  end

  // software control fields
  always_comb begin
    next_ctrl    = ctrl;
    next_clr_bit = clr_bit;
    next_ready   = i_slow_osc_stable;
    if (wr_ctrl) begin
      next_ctrl.enable = i_pwdata[EN_POS];
      next_ctrl.trim   = i_pwdata[TRIM_LSB +: TRIM_W];
    end
    if (wr_cause) begin
      next_clr_bit = i_pwdata[CLR_POS];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl.enable <= 1'b0;
      ctrl.trim   <= TRIM_RST;
      clr_bit     <= 1'b0;
      ready       <= 1'b0;
    end else if (i_clk_en) begin
      ctrl    <= next_ctrl;
      clr_bit <= next_clr_bit;
      ready   <= next_ready;
    end
  end

  assign o_slow_osc_trim = ctrl.trim;

  // frequency measurement
  assign slow_rise = i_slow_osc_clock & ~slow_q;

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_count   = count;
    next_periods = periods;
    next_done    = done;
    next_slow_q  = i_slow_osc_clock;
    case (state)
      ST_IDLE: begin
        if (ctrl.enable) begin
          next_state = ST_ARM;
        end
      end
      ST_ARM: begin
        if (!ctrl.enable) begin
          next_state = ST_IDLE;
        end else if (slow_rise) begin
          next_state   = ST_COUNT;
          next_cnt     = '0;
          next_periods = '0;
        end
      end
      ST_COUNT: begin
        if (!ctrl.enable) begin
          next_state = ST_IDLE;
        end else begin
          if (i_fast_osc_tick && !(&cnt)) begin
            next_cnt = cnt + 1'b1;
          end
          if (slow_rise) begin
            if (periods == PW'(PERIODS - 1)) begin
              next_count = next_cnt;
              next_done  = 1'b1;
              next_state = ST_DONE;
            end else begin
              next_periods = periods + 1'b1;
            end
          end
        end
      end
      ST_DONE: begin
        if (!ctrl.enable) begin
          next_done  = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state   <= ST_IDLE;
      cnt     <= '0;
      count   <= '0;
      periods <= '0;
      done    <= 1'b0;
      slow_q  <= 1'b0;
    end else if (i_clk_en) begin
      state   <= next_state;
      cnt     <= next_cnt;
      count   <= next_count;
      periods <= next_periods;
      done    <= next_done;
      slow_q  <= next_slow_q;
    end
  end

  // reset-cause record, set wins over clear
  assign cause_clr = wr_cause & i_pwdata[CLR_POS];

  always_comb begin
    next_cause = socrc_cause_t'((cause & ~{CAUSE_W{cause_clr}})
                              | i_reset_cause);
  end

  always_ff @(posedge i_sys_clk or negedge i_por_b) begin
    if (!i_por_b) begin
      cause <= '0;
    end else if (i_clk_en) begin
      cause <= next_cause;
    end
  end

  // interrupt status, enable and line
  assign done_ev  = next_done & ~done;
  assign cause_ev = |(next_cause & ~cause);

  always_comb begin
    iev                = '0;
    iev[IRQ_DONE_POS]  = done_ev;
    iev[IRQ_CAUSE_POS] = cause_ev;
    next_ists = ists;
    if (wr_iclr) begin
      next_ists = ists & ~i_pwdata[IRQ_W-1:0];
    end
    next_ists = next_ists | iev;
    next_ien  = wr_ien ? i_pwdata[IRQ_W-1:0] : ien;
    next_irq  = |(next_ists & next_ien);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ists  <= '0;
      ien   <= IEN_RST;
      o_irq <= 1'b0;
    end else if (i_clk_en) begin
      ists  <= next_ists;
      ien   <= next_ien;
      o_irq <= next_irq;
    end
  end

  // checks
  a_done_clear: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    (i_clk_en && !ctrl.enable && done) |=> !done)
    else $error("done flag not cleared after disable");

  a_count_hold: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    (done && $past(done)) |-> $stable(count))
    else $error("latched count changed while done");

  a_tick_count: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    (i_clk_en && state == ST_COUNT && ctrl.enable && !slow_rise
     && i_fast_osc_tick && !(&cnt)) |=> cnt == $past(cnt) + 1'b1)
    else $error("fast tick not counted");

  a_enable_start: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    (i_clk_en && state == ST_IDLE && ctrl.enable) |=> state == ST_ARM)
    else $error("measurement did not start");

  a_trim_write: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    (i_clk_en && wr_ctrl) |=>
      o_slow_osc_trim == $past(i_pwdata[TRIM_LSB +: TRIM_W]))
    else $error("trim write lost");

  a_ready_track: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    (i_clk_en && i_rst_b) |=> ready == $past(i_slow_osc_stable))
    else $error("ready flag does not follow stability");

  a_cause_set: assert property (@(posedge i_sys_clk)
    disable iff (!i_por_b)
    (i_clk_en && i_reset_cause != '0) |=>
      (cause & $past(i_reset_cause)) == $past(i_reset_cause))
    else $error("reset cause not recorded");

  a_cause_clear: assert property (@(posedge i_sys_clk)
    disable iff (!i_por_b || !i_rst_b)
    (i_clk_en && cause_clr && i_reset_cause == '0) |=> cause == '0)
    else $error("cause flags not cleared");

  a_eight_periods: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    $rose(done) |-> $past(state) == ST_COUNT
      && $past(periods) == PW'(PERIODS - 1))
    else $error("done raised before all slow periods");

  a_reserved_zero: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    (commit && !i_pwrite && hit(i_paddr, SOCRC_CTRL_OFS)) |->
      o_prdata[31:DONE_POS+1] == '0 && o_prdata[0] == 1'b0)
    else $error("reserved bits not zero");

  a_done_irq: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    ($rose(done) && ien[IRQ_DONE_POS]) |-> o_irq)
    else $error("enabled done event raised no interrupt");

  a_apb_wait: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_b)
    (i_clk_en && acc && !o_pready) |=> o_pready)
    else $error("apb access not answered");

  c_measure_done: cover property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) $rose(done));
  c_cause_clear: cover property (@(posedge i_sys_clk)
    disable iff (!i_por_b) cause_clr && cause != '0);
  c_irq_line: cover property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) $rose(o_irq));
  c_bad_addr: cover property (@(posedge i_sys_clk)
    disable iff (!i_rst_b) o_pready && o_pslverr);

endmodule

// ---- inc/socrc_pkg.sv ----
// package: register map, field layout and types of the slow oscillator block
package socrc_pkg;

  // register byte offsets
  localparam logic [7:0] SOCRC_CTRL_OFS  = 8'h18;
  localparam logic [7:0] SOCRC_CAUSE_OFS = 8'h1c;
  localparam logic [7:0] SOCRC_ISTS_OFS  = 8'h28;
  localparam logic [7:0] SOCRC_ICLR_OFS  = 8'h2c;
  localparam logic [7:0] SOCRC_IEN_OFS   = 8'h30;

  // slow_osc_control fields
  localparam int DONE_POS  = 24;
  localparam int COUNT_LSB = 8;
  localparam int COUNT_W   = 16;
  localparam int EN_POS    = 7;
  localparam int TRIM_LSB  = 2;
  localparam int TRIM_W    = 5;
  localparam int READY_POS = 1;

  // reset_cause_status fields, index 6 is clamp down to index 0 pin
  localparam int CAUSE_W   = 7;
  localparam int CAUSE_POS [CAUSE_W-1:0] = '{11, 8, 7, 6, 5, 4, 3};
  localparam int CLR_POS   = 0;

  // interrupt status, clear and enable layout
  localparam int IRQ_W         = 2;
  localparam int IRQ_DONE_POS  = 0;
  localparam int IRQ_CAUSE_POS = 1;

  // reset values
  localparam logic [TRIM_W-1:0] TRIM_RST = 5'h10;
  localparam logic [IRQ_W-1:0]  IEN_RST  = 2'h0;

  // slow clock periods timed per measurement
  localparam int SLOW_PERIODS = 8;

  typedef struct packed {
    logic clamp;
    logic low_power;
    logic low_voltage;
    logic watchdog;
    logic software;
    logic power_on;
    logic pin;
  } socrc_cause_t;

  typedef struct packed {
    logic              enable;
    logic [TRIM_W-1:0] trim;
  } socrc_ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_COUNT,
    ST_DONE
  } socrc_state_t;

endpackage

// ---- dv/socrc_ctrl_bench.sv ----
// self-checking bench for the slow oscillator and reset-cause block
`timescale 1ns/1ps
module socrc_ctrl_bench;
  import socrc_pkg::*;
  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] exp;
    logic        err;
  } socrc_note_t;

  logic         clk, rst_b, por_b, psel, pen, pwr, slow, tick, stab;
  logic         irq, err, pready, cke;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, d, acc;
  logic [4:0]   trim_o;
  socrc_cause_t cause;
  socrc_note_t  nt;
  socrc_note_t  q[$];
  int           error_cnt, check_count, seed, tmode, n, cnt;
  int           per = 4;

  socrc_ctrl uut (
    .i_sys_clk        (clk),
    .i_rst_b          (rst_b),
    .i_por_b          (por_b),
    .i_clk_en         (cke),
    .i_psel           (psel),
    .i_penable        (pen),
    .i_pwrite         (pwr),
    .i_paddr          (paddr),
    .i_pwdata         (pwdata),
    .o_prdata         (prdata),
    .o_pready         (pready),
    .o_pslverr        (err),
    .i_slow_osc_clock (slow),
    .i_fast_osc_tick  (tick),
    .i_slow_osc_stable(stab),
    .i_reset_cause    (cause),
    .o_slow_osc_trim  (trim_o),
    .o_irq            (irq)
  );

  always #12.5 clk = ~clk;

  // free-running slow oscillator, period per system cycles
  always begin
    repeat (per / 2) @(posedge clk);
    slow <= ~slow;
  end

  // fast tick every cycle, or every other cycle in mode 1
  always @(posedge clk) tick <= (tmode != 0) ? ~tick : 1'b1;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // answer monitor: oldest note against each completed access
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (q.size() == 0) begin
        chk("unexpected answer", 32'h0, 32'h1);
      end else begin
        nt = q.pop_front();
        chk("pslverr", {31'h0, nt.err}, {31'h0, err});
        chk("prdata", nt.exp & nt.mask, prdata & nt.mask);
      end
    end
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] dt, input logic [31:0] m,
                     input logic [31:0] e, input logic r);
    @(posedge clk);
    q.push_back('{m, e, r});
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dt,
                    input logic r = 1'b0);
    apb(1'b1, a, dt, 32'h0, 32'h0, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffffffff,
                    input logic r = 1'b0);
    apb(1'b0, a, 32'h0, m, e, r);
  endtask

  task automatic ck_irq(input logic e);
    @(negedge clk);
    chk("o_irq", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic fire(input logic [6:0] v);
    cause <= v;
    @(posedge clk);
    cause <= 7'h00;
    @(posedge clk);
  endtask

  function automatic logic [31:0] cmap(input logic [6:0] v);
    cmap = 32'h0;
    for (int i = 0; i < CAUSE_W; i++) begin
      if (v[i]) cmap[CAUSE_POS[i]] = 1'b1;
    end
  endfunction

  task automatic final_report();
    if (q.size() != 0) begin
      error_cnt++;
    end
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  initial begin
    clk = 1'b0; rst_b = 1'b0; por_b = 1'b0; psel = 1'b0; pen = 1'b0;
    pwr = 1'b0; paddr = 8'h00; pwdata = 32'h0; slow = 1'b0; tick = 1'b1;
    stab = 1'b0; cause = 7'h00; seed = 66162; per = 4; tmode = 0;
    error_cnt = 0; check_count = 0; cke = 1'b1;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    rd(SOCRC_CTRL_OFS, 32'h40);
    rd(SOCRC_CAUSE_OFS, 32'h0);
    rd(SOCRC_IEN_OFS, 32'h0);
    rd(SOCRC_ISTS_OFS, 32'h0);
    rd(8'h20, 32'h0, 32'hffffffff, 1'b1);
    wr(8'h24, 32'hffffffff, 1'b1);
    stab <= 1'b1;
    rd(SOCRC_CTRL_OFS, 32'h42);
    stab <= 1'b0;
    rd(SOCRC_CTRL_OFS, 32'h40);
    stab <= 1'b1;
    fork
      rd(SOCRC_CTRL_OFS, 32'h42);
      begin
        repeat (2) @(posedge clk);
        cke <= 1'b0;
        repeat (3) @(posedge clk);
        cke <= 1'b1;
      end
    join
    $display("test reset_values done");
    for (int k = 0; k < 4; k++) begin
      d = $random(seed) & 32'hffffff7f;
      wr(SOCRC_CTRL_OFS, d);
      rd(SOCRC_CTRL_OFS, {25'h0, d[6:2], 2'b10});
      chk("trim", {27'h0, d[6:2]}, {27'h0, trim_o});
      wr(SOCRC_CAUSE_OFS, d & 32'hfffffffe);
      rd(SOCRC_CAUSE_OFS, 32'h0);
    end
    $display("test trim_fields done");
    wr(SOCRC_IEN_OFS, 32'h1);
    for (int m = 0; m < 2; m++) begin
      tmode = m;
      per = 4 + 2 * ($unsigned($random(seed)) % 8);
      repeat (20) @(posedge clk);
      wr(SOCRC_CTRL_OFS, 32'hc0);
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
        @(posedge clk);
        n++;
      end
      cnt = (m != 0 ? 4 : 8) * per;
      ck_irq(1'b1);
      rd(SOCRC_CTRL_OFS, 32'h010000c2 | (cnt << 8));
      rd(SOCRC_ISTS_OFS, 32'h1);
      wr(SOCRC_IEN_OFS, 32'h0);
      ck_irq(1'b0);
      wr(SOCRC_IEN_OFS, 32'h1);
      ck_irq(1'b1);
      wr(SOCRC_ICLR_OFS, 32'h1);
      rd(SOCRC_ISTS_OFS, 32'h0);
      ck_irq(1'b0);
      wr(SOCRC_CTRL_OFS, 32'h40);
      rd(SOCRC_CTRL_OFS, 32'h42 | (cnt << 8));
    end
    wr(SOCRC_CTRL_OFS, 32'hc0);
    wr(SOCRC_CTRL_OFS, 32'h40);
    repeat (12 * per) @(posedge clk);
    ck_irq(1'b0);
    rd(SOCRC_CTRL_OFS, 32'h42, 32'hff0000ff);
    $display("test measurement done");
    wr(SOCRC_IEN_OFS, 32'h2);
    acc = 32'h0;
    for (int i = 0; i < CAUSE_W; i++) begin
      fire(7'(1 << i));
      acc = acc | cmap(7'(1 << i));
      rd(SOCRC_CAUSE_OFS, acc);
    end
    ck_irq(1'b1);
    wr(SOCRC_ICLR_OFS, 32'h2);
    rd(SOCRC_ISTS_OFS, 32'h0);
    ck_irq(1'b0);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(SOCRC_CAUSE_OFS, acc);
    rd(SOCRC_CTRL_OFS, 32'h42);
    rd(SOCRC_IEN_OFS, 32'h0);
    wr(SOCRC_CAUSE_OFS, 32'h1);
    rd(SOCRC_CAUSE_OFS, 32'h1);
    wr(SOCRC_CAUSE_OFS, 32'h0);
    rd(SOCRC_CAUSE_OFS, 32'h0);
    for (int k = 0; k < 3; k++) begin
      d = $random(seed);
      fire(d[6:0]);
      rd(SOCRC_CAUSE_OFS, cmap(d[6:0]) | 32'(k > 0));
      wr(SOCRC_CAUSE_OFS, 32'h1);
      rd(SOCRC_CAUSE_OFS, 32'h1);
    end
    fork
      wr(SOCRC_CAUSE_OFS, 32'h1);
      begin
        repeat (3) @(posedge clk);
        cause <= 7'h01;
        @(posedge clk);
        cause <= 7'h00;
      end
    join
    rd(SOCRC_CAUSE_OFS, cmap(7'h01) | 32'h1);
    $display("test reset_cause done");
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule
